// >>> design/wrg_core_if.sv
// Signals between the watchdog core, its prescaler and its reset pulse.
// Assumes all three parties sit on the same clock.
`timescale 1ns/1ps
interface wrg_core_if;
   logic run;
   logic clear;
   logic wd_tick;
   logic ovf;
   logic pulse_active;

   modport presc (input run, input clear, output wd_tick);
   modport pulse (input ovf, output pulse_active);
   modport core  (output run, output clear, output ovf, input wd_tick, input pulse_active);
endinterface

// >>> design/wrg_params.svh
// Constants for the watchdog reload guard: offsets, fields, resets, timing.
// Assumes an includer that wants plain `define names; no logic lives here.
// What this block does
// (RULE1) 8-bit counter advanced through an 11-bit prescaler fed at clock/6.
// (RULE2) Counter overflow raises internal reset and a three machine cycle pin pulse.
// (RULE3) Strap low runs the watchdog; software has no way to stop it.
// (RULE4) Strap high keeps the watchdog disabled; it never resets the chip.
// (RULE5) Software must reload the counter before the interval runs out.
// (RULE6) Interval spans one to 256 counter steps, scaling inversely with clock.
// (RULE7) Reload is two steps: set unlock bit 4, then write the counter.
// (RULE8) Counter write while unlocked loads the value and clears the unlock bit.
// (RULE9) Counter write while locked is ignored; the counter keeps its value.
// (RULE10) Counter counts up; reload 00H gives longest, 0FFH shortest interval.
// (RULE11) Prescaler and counter keep running in idle mode.
// (RULE12) With watchdog enabled, power-down bit cannot be set and reads 0.
// (RULE13) Software sizes service intervals from worst-case execution times.
// (RULE14) Software sets the unlock bit outside a reload routine reachable in error.
// (RULE15) Chip reset, watchdog reset included, clears unlock, prescaler and counter.
`ifndef WRG_PARAMS_SVH
`define WRG_PARAMS_SVH

// Register indices; byte address is four times the index
`define WRG_IDX_POWER_CONTROL  8'h87
`define WRG_IDX_WATCHDOG_COUNT 8'hFF
`define WRG_ADDR_W             10

// Power control fields, reset values and the counter maximum
`define WRG_UNLOCK_BIT         4
`define WRG_PDOWN_BIT          1
`define WRG_POWER_CONTROL_RESET         8'h00
`define WRG_COUNT_RESET        8'h00
`define WRG_COUNT_MAX          8'hFF

// Timing counts: divider in clock cycles, prescaler length and pulse width in machine cycles
`define WRG_MC_DIV             6
`define WRG_PRESC_LEN          2048
`define WRG_PULSE_MC           3

`endif

// >>> design/wrg_pkg.sv
// Types shared by the watchdog reload guard modules.
// Assumes the bus carries 32-bit words.
package wrg_pkg;
   typedef logic [31:0] wrg_word_t;
   typedef logic [7:0]  wrg_byte_t;
   typedef enum logic [1:0] {
      WRG_SEL_NONE,
      WRG_SEL_POWER_CONTROL,
      WRG_SEL_COUNT
   } wrg_sel_t;
endpackage

// >>> design/wrg_prescaler.sv
// Divide-by-six stage and 11-bit prescaler producing the counter step.
// Assumes run and clear come from logic on the same clock.
`timescale 1ns/1ps
`include "wrg_params.svh"
module wrg_prescaler #(
   parameter int unsigned MC_DIV    = `WRG_MC_DIV,
   parameter int unsigned PRESC_LEN = `WRG_PRESC_LEN
) (
   input wire logic core_clk,
   input wire logic rst_b,
   wrg_core_if.presc cif
);
   import wrg_pkg::*;
   localparam int MCW = $clog2(MC_DIV);
   localparam int PSW = $clog2(PRESC_LEN);
   logic [MCW-1:0] mc_cnt;
   logic [PSW-1:0] ps_cnt;
   logic [MCW-1:0] next_mc_cnt;
   logic [PSW-1:0] next_ps_cnt;
   logic           mc_end;
   logic           ps_end;

   // Step once per machine cycle; no idle input, so idle never stops it
   always_comb begin
      mc_end      = (mc_cnt == MCW'(MC_DIV - 1));
      ps_end      = (ps_cnt == PSW'(PRESC_LEN - 1));
      next_mc_cnt = mc_end ? '0 : mc_cnt + MCW'(1);           // RULE1
      next_ps_cnt = ps_cnt;
      if (cif.clear) begin
         next_mc_cnt = '0;                                     // RULE15
         next_ps_cnt = '0;
      end else if (cif.run && mc_end) begin
         next_ps_cnt = ps_end ? '0 : ps_cnt + PSW'(1);         // RULE11
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         mc_cnt <= '0;
         ps_cnt <= '0;
      end else begin
         mc_cnt <= next_mc_cnt;
         ps_cnt <= next_ps_cnt;
      end
   end

   assign cif.wd_tick = cif.run && !cif.clear && mc_end && ps_end;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   a_tick_spacing: assert property (cif.wd_tick |=> (!cif.wd_tick) [*7]) // RULE1
      else $error("counter step came too soon after the previous one");
endmodule

// >>> design/wrg_reload_guard.sv
// Watchdog reload guard top: APB registers, counter, strap and power-down lock.
// Assumes an APB master on core_clk and the enable strap as an asynchronous pin.
`timescale 1ns/1ps
`include "wrg_params.svh"
module wrg_reload_guard #(
   parameter int unsigned PRESC_LEN = `WRG_PRESC_LEN,
   parameter int unsigned MC_DIV    = `WRG_MC_DIV
) (
   input  wire logic                  core_clk,
   input  wire logic                  rst_b,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [`WRG_ADDR_W-1:0] paddr,
   input  wire wrg_pkg::wrg_word_t    pwdata,
   output wrg_pkg::wrg_word_t         prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic                  watchdog_strap_n,
   output logic                       chip_reset,
   output logic                       rst_pin_o,
   output logic                       rst_pin_oe,
   output logic                       powerdown_req,
   output logic                       watchdog_active
);
   import wrg_pkg::*;

   localparam wrg_byte_t FIELD_MASK = wrg_byte_t'((1 << `WRG_UNLOCK_BIT) |
                                                  (1 << `WRG_PDOWN_BIT));
   localparam logic [`WRG_ADDR_W-1:0] ADDR_POWER_CONTROL  = {`WRG_IDX_POWER_CONTROL, 2'b00};
   localparam logic [`WRG_ADDR_W-1:0] ADDR_COUNT = {`WRG_IDX_WATCHDOG_COUNT, 2'b00};

   wrg_core_if cif ();

   // Strap synchroniser; starts disabled until the pin has been seen
   logic strap_meta;
   logic strap_sync;
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         strap_meta <= 1'b1;
         strap_sync <= 1'b1;
      end else begin
         strap_meta <= watchdog_strap_n;
         strap_sync <= strap_meta;
      end
   end

   logic enabled;
   assign enabled = !strap_sync;                                 // RULE3

   // Address decode
   wrg_sel_t sel;
   always_comb begin
      if (paddr == ADDR_POWER_CONTROL) begin
         sel = WRG_SEL_POWER_CONTROL;
      end else if (paddr == ADDR_COUNT) begin
         sel = WRG_SEL_COUNT;
      end else begin
         sel = WRG_SEL_NONE;
      end
   end

   // One wait state, so read data can come straight from a flip-flop
   logic ack;
   logic next_ack;
   logic access;
   logic commit;
   logic wr_power_control;
   logic wr_count;
   always_comb begin
      access   = psel && penable;
      next_ack = access && !ack;
      commit   = access && ack;
      wr_power_control  = commit && pwrite && (sel == WRG_SEL_POWER_CONTROL);
      wr_count = commit && pwrite && (sel == WRG_SEL_COUNT);
   end

   // Watchdog and power control state
   logic      unlock;
   logic      pdown;
   wrg_byte_t pc_other;
   wrg_byte_t counter;
   wrg_byte_t power_control_view;
   wrg_word_t rdata;
   logic      next_unlock;
   logic      next_pdown;
   wrg_byte_t next_pc_other;
   wrg_byte_t next_counter;
   wrg_word_t next_rdata;
   logic      ovf;
   logic      reload;

   always_comb begin
      power_control_view                  = pc_other;
      power_control_view[`WRG_UNLOCK_BIT] = unlock;
      power_control_view[`WRG_PDOWN_BIT]  = pdown;
   end

   // Next state; a running reset pulse is the chip reset and wins over all
   always_comb begin
      next_unlock   = unlock;
      next_pdown    = pdown;
      next_pc_other = pc_other;
      next_counter  = counter;
      ovf           = 1'b0;
      reload        = 1'b0;
      if (cif.pulse_active) begin
         next_unlock   = 1'b0;                                   // RULE15
         next_pdown    = 1'b0;
         next_pc_other = `WRG_POWER_CONTROL_RESET;
         next_counter  = `WRG_COUNT_RESET;
      end else begin
         if (wr_power_control) begin
            next_pc_other = pwdata[7:0] & ~FIELD_MASK;
            next_unlock   = pwdata[`WRG_UNLOCK_BIT];             // RULE7
            next_pdown    = pwdata[`WRG_PDOWN_BIT];
         end
         if (wr_count && unlock) begin                           // RULE9
            next_counter = pwdata[7:0];                          // RULE8
            next_unlock  = 1'b0;
            reload       = 1'b1;
         end else if (enabled && cif.wd_tick) begin
            // Up-counter: steps left are 256 minus the reload value
            next_counter = counter + 8'h01;                      // RULE10
            ovf          = (counter == `WRG_COUNT_MAX);          // RULE6
         end
         // Locked counter writes fall through and change nothing
         if (enabled) begin
            next_pdown = 1'b0;                                   // RULE12
         end
      end
   end

   // Read data captured in the first access cycle
   always_comb begin
      next_rdata = rdata;
      if (access && !ack && !pwrite) begin
         if (sel == WRG_SEL_POWER_CONTROL) begin
            next_rdata = {24'h000000, power_control_view};
         end else if (sel == WRG_SEL_COUNT) begin
            next_rdata = {24'h000000, counter};
         end else begin
            next_rdata = 32'h00000000;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         ack      <= 1'b0;
         unlock   <= 1'b0;
         pdown    <= 1'b0;
         pc_other <= `WRG_POWER_CONTROL_RESET;
         counter  <= `WRG_COUNT_RESET;
         rdata    <= 32'h00000000;
      end else begin
         ack      <= next_ack;
         unlock   <= next_unlock;
         pdown    <= next_pdown;
         pc_other <= next_pc_other;
         counter  <= next_counter;
         rdata    <= next_rdata;
      end
   end

   // Core side of the shared interface
   assign cif.run   = enabled && !cif.pulse_active;              // RULE4
   assign cif.clear = cif.pulse_active || reload;
   assign cif.ovf   = ovf && enabled;                            // RULE2

   wrg_prescaler #(
      .MC_DIV    (MC_DIV),
      .PRESC_LEN (PRESC_LEN)
   ) wrg_prescaler_inst (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .cif      (cif.presc)
   );

   wrg_rst_pulse #(
      .PULSE_CLKS (`WRG_PULSE_MC * MC_DIV)
   ) wrg_rst_pulse_inst (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .cif      (cif.pulse)
   );

   // Outputs; the pin pulse may be swallowed by a capacitor on the board
   assign prdata          = rdata;
   assign pready          = ack;
   assign pslverr         = ack && (sel == WRG_SEL_NONE);
   assign chip_reset      = cif.pulse_active;
   assign rst_pin_o       = 1'b1;
   assign rst_pin_oe      = cif.pulse_active;
   assign powerdown_req   = pdown;
   assign watchdog_active = enabled;

   // Assertion helper: low byte of the write data
   wrg_byte_t pw_byte;
   assign pw_byte = pwdata[7:0];

   // Cycles since the last counter step; an enabled watchdog must step
   // at least every STEP_CLKS cycles between reloads, whatever software does
   localparam int unsigned STEP_CLKS = MC_DIV * PRESC_LEN;
   logic [31:0] since_tick;
   logic [31:0] next_since_tick;
   always_comb begin
      next_since_tick = since_tick + 32'h00000001;
      if (!enabled || cif.clear || cif.wd_tick) begin
         next_since_tick = 32'h00000000;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         since_tick <= 32'h00000000;
      end else begin
         since_tick <= next_since_tick;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sequence s_count_write_open;
      wr_count && unlock && !cif.pulse_active;
   endsequence
   sequence s_count_write_shut;
      wr_count && !unlock && !cif.pulse_active && !cif.wd_tick;
   endsequence

   a_unlock_self_clear: assert property (s_count_write_open |=>        // RULE8
      !unlock && counter == $past(pw_byte))
      else $error("unlocked reload did not load or did not relock");
   a_locked_write_ignored: assert property (s_count_write_shut |=>     // RULE9
      counter == $past(counter))
      else $error("locked counter write changed the counter");
   a_pdown_blocked: assert property (enabled && $past(enabled) |->     // RULE12
      !pdown && !powerdown_req)
      else $error("power-down bit set while watchdog enabled");
   a_strap_off_silent: assert property (!enabled && !chip_reset |=> !chip_reset) // RULE4
      else $error("reset pulse started with watchdog disabled");
   a_overflow_fires: assert property (enabled && cif.wd_tick &&        // RULE2
      counter == 8'hFF && !wr_count && !cif.pulse_active |=> chip_reset ##1 rst_pin_oe)
      else $error("counter overflow did not reset the chip");
   a_count_steps_up: assert property (enabled && cif.wd_tick &&        // RULE10
      counter != 8'hFF && !wr_count && !cif.pulse_active |=>
      counter == $past(counter) + 8'h01)
      else $error("counter did not step up on prescaler tick");
   a_reset_clears: assert property (chip_reset |=>                     // RULE15
      counter == 8'h00 && !unlock)
      else $error("watchdog reset left state uncleared");
   a_enabled_runs: assert property (since_tick < STEP_CLKS)            // RULE3
      else $error("enabled watchdog was stopped");
   a_apb_ready: assert property (access && !ack |=> pready ##1 !pready)
      else $error("APB slave did not answer after one wait state");
   a_unmapped_err: assert property (access && !ack && sel == WRG_SEL_NONE |=>
      pready && pslverr)
      else $error("unmapped address answered without an error");

   // Read path: data captured in the first access cycle
   sequence s_read_power_control;
      access && !ack && !pwrite && sel == WRG_SEL_POWER_CONTROL && enabled && $past(enabled);
   endsequence
   sequence s_read_count;
      access && !ack && !pwrite && sel == WRG_SEL_COUNT;
   endsequence

   a_pdown_reads_zero: assert property (s_read_power_control |=> !prdata[`WRG_PDOWN_BIT]) // RULE12
      else $error("power-down bit read back as one while enabled");
   a_count_readback: assert property (s_read_count |=>                 // RULE10
      prdata == {24'h000000, $past(counter)})
      else $error("counter read returned a stale or wrong value");

   // Unlock bit follows software writes; locked writes leave it clear
   a_unlock_set: assert property (wr_power_control && !cif.pulse_active &&      // RULE7
      pwdata[`WRG_UNLOCK_BIT] |=> unlock)
      else $error("unlock bit not set by power control write");
   a_unlock_drop: assert property (wr_power_control && !cif.pulse_active &&     // RULE7
      !pwdata[`WRG_UNLOCK_BIT] |=> !unlock)
      else $error("unlock bit not cleared by power control write");
   a_locked_stays_shut: assert property (s_count_write_shut |=> !unlock) // RULE9
      else $error("locked counter write opened the unlock bit");
   a_reload_restarts: assert property (reload |=> (!cif.wd_tick) [*7]) // RULE8
      else $error("prescaler not restarted by a reload");

   // Strap gating, counter freeze and power-down permission
   a_strap_sync: assert property ($past(rst_b) && $past(rst_b, 2) |->  // RULE3
      enabled == !$past(watchdog_strap_n, 2))
      else $error("enable does not follow the strap two clocks later");
   a_tick_gated: assert property (!enabled |-> !cif.wd_tick)           // RULE4
      else $error("counter step while watchdog disabled");
   a_disabled_frozen: assert property (!enabled && !chip_reset &&      // RULE4
      !(wr_count && unlock) |=> counter == $past(counter))
      else $error("disabled watchdog counter moved");
   a_pdown_free: assert property (!enabled && wr_power_control &&               // RULE12
      !cif.pulse_active && pwdata[`WRG_PDOWN_BIT] |=> powerdown_req)
      else $error("power-down refused while watchdog disabled");
   a_ovf_at_max: assert property (cif.ovf |-> cif.wd_tick &&           // RULE6
      counter == `WRG_COUNT_MAX)
      else $error("overflow outside a step from the top count");
   a_power_control_cleared: assert property (chip_reset |=>                     // RULE15
      power_control_view == `WRG_POWER_CONTROL_RESET && !powerdown_req)
      else $error("watchdog reset left power control uncleared");
endmodule

// >>> design/wrg_rst_pulse.sv
// Reset pulse stretcher: holds the chip reset for three machine cycles.
// Assumes ovf is a one-cycle request from the core on the same clock.
`timescale 1ns/1ps
`include "wrg_params.svh"
module wrg_rst_pulse #(
   parameter int unsigned PULSE_CLKS = `WRG_PULSE_MC * `WRG_MC_DIV
) (
   input wire logic core_clk,
   input wire logic rst_b,
   wrg_core_if.pulse cif
);
   import wrg_pkg::*;
   localparam int PW = $clog2(PULSE_CLKS + 1);
   logic [PW-1:0] left;
   logic [PW-1:0] next_left;
   logic          active;
   logic          next_active;

   // Exact clock count instead of machine ticks, so the width never jitters
   always_comb begin
      next_left   = left;
      next_active = active;
      if (!active && cif.ovf) begin
         next_left   = PW'(PULSE_CLKS - 1);                    // RULE2
         next_active = 1'b1;
      end else if (active) begin
         next_left   = left - PW'(1);
         next_active = (left != '0);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         left   <= '0;
         active <= 1'b0;
      end else begin
         left   <= next_left;
         active <= next_active;
      end
   end

   assign cif.pulse_active = active;

   // Assertion helper: cycles the pulse has been up, counted apart from left
   logic [PW-1:0] held;
   logic [PW-1:0] next_held;
   always_comb begin
      next_held = '0;
      if (active) begin
         next_held = held + PW'(1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         held <= '0;
      end else begin
         held <= next_held;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   sequence s_pulse_start;
      cif.ovf && !active;
   endsequence
   a_pulse_starts: assert property (s_pulse_start |=>                  // RULE2
      active && left == PW'(PULSE_CLKS - 1))
      else $error("reset pulse did not start on overflow");
   a_pulse_length: assert property ($fell(active) |-> held == PW'(PULSE_CLKS)) // RULE2
      else $error("reset pulse width is not three machine cycles");
endmodule

// >>> tb/wrg_apb_master.sv
// APB master standing in for CPU software that writes the special registers.
// Assumes one clock shared with the block and a bench that bounds every wait.
`timescale 1ns/1ps
module wrg_apb_master (
   input  wire logic         core_clk,
   output logic              psel,
   output logic              penable,
   output logic              pwrite,
   output logic [9:0]        paddr,
   output wrg_pkg::wrg_word_t pwdata,
   input  wire logic         pready,
   input  wire logic         pslverr,
   input  wire wrg_pkg::wrg_word_t prdata
);
   import wrg_pkg::*;

   // Idle bus from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 10'h000;
      pwdata = 32'h0000_0000;
   end

   // One transfer; request held until pready is seen high at an edge
   task automatic xfer(input logic wr, input logic [9:0] a, input wrg_word_t d,
                       output wrg_word_t q, output logic err);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1); // No fixed latency assumed
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// >>> tb/wrg_reload_guard_tb.sv
// Self-checking bench for the watchdog reload guard, short prescaler settings.
// Assumes the APB master model above; idle mode has no input, so never tested.
`timescale 1ns/1ps
`include "wrg_params.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
   $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
module wrg_reload_guard_tb;
   import wrg_pkg::*;
   localparam int unsigned PL   = 4;
   localparam int unsigned MD   = 2;
   localparam int unsigned STEP = PL * MD;
   localparam logic [9:0] A_PC = {`WRG_IDX_POWER_CONTROL, 2'b00};
   localparam logic [9:0] A_WC = {`WRG_IDX_WATCHDOG_COUNT, 2'b00};

   logic      core_clk = 1'b0;
   logic      rst_b = 1'b0;
   logic      psel, penable, pwrite, pready, pslverr;
   logic [9:0] paddr;
   wrg_word_t pwdata, prdata, q;
   logic      err, strap_n = 1'b1;
   logic      chip_reset, rst_pin_o, rst_pin_oe, powerdown_req, watchdog_active;
   int        mismatches = 0, comparisons = 0, cyc = 0, rst_cycles = 0;
   int        n_ff, n_fe, n_00;

   // Clock at 40 MHz
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end

   wrg_apb_master wrg_apb_master_inst (.core_clk(core_clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
      .prdata(prdata));
   wrg_reload_guard #(.PRESC_LEN(PL), .MC_DIV(MD)) wrg_reload_guard_inst (
      .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .watchdog_strap_n(strap_n), .chip_reset(chip_reset), .rst_pin_o(rst_pin_o),
      .rst_pin_oe(rst_pin_oe), .powerdown_req(powerdown_req),
      .watchdog_active(watchdog_active));

   // Cycle count for the hang limit, and a tally of reset cycles
   always @(posedge core_clk) begin
      cyc++;
      if (chip_reset === 1'b1) rst_cycles++;
      if (cyc == 20000) begin
         mismatches++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      wrg_apb_master_inst.xfer(1'b1, a, {24'h000000, d}, q, err);
   endtask
   task automatic rd(input logic [9:0] a);
      wrg_apb_master_inst.xfer(1'b0, a, 32'h0000_0000, q, err);
   endtask
   // Unlock first, then write the counter
   task automatic reload(input logic [7:0] v);
      wr(A_PC, 8'h10);
      wr(A_WC, v);
   endtask
   // Cycles from reload to reset, then the pulse length and pin drive
   task automatic fire(input logic [7:0] v, output int n);
      int p;
      reload(v);
      n = 0;
      while (chip_reset !== 1'b1 && n < 3000) begin @(negedge core_clk); n++; end
      `CHK(rst_pin_oe, 1'b1)
      `CHK(rst_pin_o, 1'b1)
      p = 0;
      while (chip_reset === 1'b1 && p < 100) begin @(negedge core_clk); p++; end
      `CHK(p, `WRG_PULSE_MC * MD)
      rd(A_PC);
      `CHK(q, 32'h0000_0000)
      rd(A_WC);
      `CHK(q, 32'h0000_0000)
   endtask

   task automatic t_reset_values();
      rd(A_PC);
      `CHK(q, 32'h0000_0000)
      rd(A_WC);
      `CHK(q, 32'h0000_0000)
      rd(10'h000);
      `CHK({err, q}, {1'b1, 32'h0000_0000})
      wr(A_WC, 8'h80);
      rd(A_WC);
      `CHK(q, 32'h0000_0000)
   endtask

   // Strap high: frozen counter, no reset, power-down allowed
   task automatic t_disabled();
      int r0;
      r0 = rst_cycles;
      reload(8'hFE);
      rd(A_PC);
      `CHK(q[4], 1'b0)
      repeat (20 * STEP) @(posedge core_clk);
      rd(A_WC);
      `CHK(q, 32'h0000_00FE)
      `CHK(rst_cycles, r0)
      // Restart from 00H so the enabled phase cannot overflow early
      reload(8'h00);
      wr(A_PC, 8'h22);
      rd(A_PC);
      `CHK(q, 32'h0000_0022)
      `CHK(powerdown_req, 1'b1)
   endtask

   // Strap low: watchdog on, power-down refused, a locked counter write is ignored
   task automatic t_enabled();
      strap_n <= 1'b0;
      repeat (4) @(posedge core_clk);
      `CHK(watchdog_active, 1'b1)
      `CHK(powerdown_req, 1'b0)
      wr(A_PC, 8'h02);
      rd(A_PC);
      `CHK(q[1], 1'b0)
      `CHK(powerdown_req, 1'b0)
      wr(A_WC, 8'hF0);
      rd(A_WC);
      `CHK(q < 32'h0000_0010, 1'b1)
   endtask

   // Timely reloads keep reset away; counter climbs meanwhile
   task automatic t_serviced();
      int r0;
      r0 = rst_cycles;
      repeat (6) begin
         reload(8'hF0);
         repeat (4 * STEP) @(posedge core_clk);
      end
      `CHK(rst_cycles, r0)
      rd(A_WC);
      `CHK(q > 32'h0000_00F2 && q < 32'h0000_00F7, 1'b1)
   endtask

   task automatic t_intervals();
      wr(A_PC, 8'h00);
      fire(8'hFF, n_ff);
      fire(8'hFE, n_fe);
      fire(8'h00, n_00);
      `CHK(n_ff >= STEP && n_ff <= STEP + 2, 1'b1)
      `CHK(n_fe - n_ff, STEP)
      `CHK(n_00 - n_ff, 255 * STEP)
   endtask

   // Reset in mid-count clears the counter and unlock bit
   task automatic t_mid_reset();
      reload(8'h40);
      wr(A_PC, 8'h10);
      @(posedge core_clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      rd(A_WC);
      `CHK(q, 32'h0000_0000)
      rd(A_PC);
      `CHK(q, 32'h0000_0000)
   endtask

   // Main sequence
   initial begin
      repeat (5) @(posedge core_clk);
      rst_b <= 1'b1;
      t_reset_values();
      t_disabled();
      t_enabled();
      t_serviced();
      t_intervals();
      t_mid_reset();
      end_of_test();
   end
endmodule
